// ==== core/mppw_pclk_tick.sv ====
`timescale 1ns/1ps
// Produces a one-cycle tick once per peripheral clock period.
module mppw_pclk_tick #(
    parameter int DIV = mppw_pkg::PCLK_DIV_CYCLES
) (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Peripheral clock tick
    output logic tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] div_reg;
    logic [CW-1:0] div_next;

    // Free-running divider; the tick marks its wrap.
    always_comb begin
        div_next = (div_reg == LAST) ? '0 : div_reg + CW'(1);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            div_reg <= '0;
        end else if (ce) begin
            div_reg <= div_next;
        end
    end

    assign tick = ce && (div_reg == LAST);

endmodule : mppw_pclk_tick

// ==== core/mppw_phase_timer.sv ====
`timescale 1ns/1ps
// Counts peripheral clock ticks for the current bus phase.
module mppw_phase_timer #(
    parameter int W = mppw_pkg::TICK_W
) (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Control
    input wire logic tick,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    // Phase ends on this tick
    output logic expired
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    // A load wins over counting, so a phase may start on the tick that ends the last.
    always_comb begin
        cnt_next = cnt_reg;
        if (load) begin
            cnt_next = load_val;
        end else if (tick && cnt_reg != '0) begin
            cnt_next = cnt_reg - W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (ce) begin
            cnt_reg <= cnt_next;
        end
    end

    assign expired = tick && (cnt_reg == W'(1));

endmodule : mppw_phase_timer

// ==== core/mppw_pkg.sv ====
package mppw_pkg;

    // ------------------------------------------------------------
    // Clocking
    // ------------------------------------------------------------
    // Core clock period in ns; the peripheral clock runs at half this rate.
    localparam int CORE_CLK_PERIOD_NS = 25;
    // Peripheral clock period expressed in core clock periods.
    localparam int PCLK_PER_CORE = 2;
    localparam int PCLK_PERIOD_NS = PCLK_PER_CORE * CORE_CLK_PERIOD_NS;
    localparam int PCLK_DIV_CYCLES = PCLK_PERIOD_NS / CORE_CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Phase lengths in peripheral clock cycles
    // ------------------------------------------------------------
    localparam int TICK_W = 6;
    localparam logic [TICK_W-1:0] ALE_TICKS = 6'h02;
    localparam logic [TICK_W-1:0] ADDR_HOLD_TICKS = 6'h01;
    localparam logic [TICK_W-1:0] DATA_SETUP_TICKS = 6'h01;
    localparam logic [TICK_W-1:0] HOLD_TICKS = 6'h01;
    localparam logic [TICK_W-1:0] FLASH_TICKS = 6'h07;
    localparam logic [TICK_W-1:0] MIN_STROBE_TICKS = 6'h01;
    localparam logic [TICK_W-1:0] FLASH_MIN_DURATION = 6'h09;

    // ------------------------------------------------------------
    // Packing and widths
    // ------------------------------------------------------------
    localparam int AD_W = 16;
    localparam int WORD_W = 32;
    localparam int DUR_W = 5;
    localparam int PACK_W = 2;
    localparam logic [1:0] BEATS_8BIT_LAST = 2'h3;
    localparam logic [1:0] BEATS_16BIT_LAST = 2'h1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [AD_W-1:0] AD_RESET = 16'h0000;
    localparam logic ALE_PIN_RESET = 1'b0;
    localparam logic WR_N_RESET = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_ALE,
        ST_ADDR_HOLD,
        ST_SETUP,
        ST_STROBE,
        ST_RECOVER
    } mppw_state_e;

endpackage : mppw_pkg

// ==== core/mppw_write_port.sv ====
`timescale 1ns/1ps
module mppw_write_port (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Configuration
    input wire logic [mppw_pkg::DUR_W-1:0] strobe_duration_field,
    input wire logic [mppw_pkg::PACK_W-1:0] packing_select,
    input wire logic mem_16bit,
    input wire logic hold_cycle_en,
    input wire logic flash_mode,
    input wire logic ale_active_low,
    // Write request
    input wire logic req_valid,
    input wire logic [mppw_pkg::AD_W-1:0] req_addr,
    input wire logic [mppw_pkg::WORD_W-1:0] req_data,
    output logic req_ready,
    // Status
    output logic busy,
    // External memory pins
    output logic ale,
    output logic wr_n,
    output logic [mppw_pkg::AD_W-1:0] muxed_addr_data_o,
    output logic muxed_addr_data_oe
);
    localparam int TW = mppw_pkg::TICK_W;
    localparam int AW = mppw_pkg::AD_W;

    // ------------------------------------------------------------
    // Peripheral tick and phase timer
    // ------------------------------------------------------------
    logic tick;
    logic expired;
    logic tmr_load;
    logic [TW-1:0] tmr_val;

    mppw_pclk_tick #(
        .DIV(mppw_pkg::PCLK_DIV_CYCLES)
    ) u_tick (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .tick(tick)
    );

    mppw_phase_timer #(
        .W(TW)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .tick(tick),
        .load(tmr_load),
        .load_val(tmr_val),
        .expired(expired)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    mppw_pkg::mppw_state_e state_reg;
    mppw_pkg::mppw_state_e state_next;
    logic [AW-1:0] addr_reg;
    logic [AW-1:0] addr_next;
    logic [mppw_pkg::WORD_W-1:0] word_reg;
    logic [mppw_pkg::WORD_W-1:0] word_next;
    logic [1:0] beat_reg;
    logic [1:0] beat_next;
    logic mode16_reg;
    logic mode16_next;
    logic pack_nz_reg;
    logic pack_nz_next;
    logic hold_reg;
    logic hold_next;
    logic flash_reg;
    logic flash_next;
    logic [mppw_pkg::DUR_W-1:0] dur_reg;
    logic [mppw_pkg::DUR_W-1:0] dur_next;
    logic ale_on_reg;
    logic ale_on_next;
    logic ale_reg;
    logic ale_next;
    logic wr_n_reg;
    logic wr_n_next;
    logic [AW-1:0] ad_reg;
    logic [AW-1:0] ad_next;
    logic oe_reg;
    logic oe_next;
    logic ready_reg;
    logic ready_next;

    // ------------------------------------------------------------
    // Derived phase lengths and beat values
    // ------------------------------------------------------------
    logic [TW-1:0] dur_ticks;
    logic [TW-1:0] strobe_ticks;
    logic [TW-1:0] hold_ticks;
    logic [TW-1:0] gap_ticks;
    logic [1:0] last_beat;
    logic group_end;
    logic [AW-1:0] beat_addr;
    logic [AW-1:0] beat_bus;
    logic [AW-1:0] next_beat_bus;
    logic [1:0] beat_inc;

    // Software must keep the duration at nine or more in flash mode; below that the
    // subtraction is clamped to one cycle rather than wrapping to a huge pulse.
    always_comb begin
        dur_ticks = TW'(dur_reg);
        if (flash_reg) begin
            strobe_ticks = (dur_ticks > mppw_pkg::FLASH_TICKS)
                ? dur_ticks - mppw_pkg::FLASH_TICKS : mppw_pkg::MIN_STROBE_TICKS;
        end else begin
            strobe_ticks = (dur_ticks != '0) ? dur_ticks : mppw_pkg::MIN_STROBE_TICKS;
        end
        hold_ticks = hold_reg ? mppw_pkg::HOLD_TICKS : '0;
        gap_ticks = hold_ticks + (flash_reg ? mppw_pkg::FLASH_TICKS : '0);
    end

    // Group shape: four bytes per latch cycle in 8-bit mode, two halves under one
    // latch cycle with zero packing, and a fresh latch cycle per half otherwise.
    always_comb begin
        beat_inc = beat_reg + 2'h1;
        last_beat = mode16_reg ? mppw_pkg::BEATS_16BIT_LAST : mppw_pkg::BEATS_8BIT_LAST;
        if (!mode16_reg) begin
            group_end = (beat_reg == last_beat);
        end else if (pack_nz_reg) begin
            group_end = 1'b1;
        end else begin
            group_end = (beat_reg == last_beat);
        end
        beat_addr = addr_reg + AW'(beat_reg);
        if (mode16_reg) begin
            beat_bus = word_reg[16*beat_reg[0] +: 16];
            next_beat_bus = word_reg[16*beat_inc[0] +: 16];
        end else begin
            beat_bus = {beat_addr[7:0], word_reg[8*beat_reg +: 8]};
            next_beat_bus = {beat_addr[7:0] + 8'h01, word_reg[8*beat_inc +: 8]};
        end
    end

    // ------------------------------------------------------------
    // Sequencer: all pin changes but an ale_active_low switch wait for a peripheral tick
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        addr_next = addr_reg;
        word_next = word_reg;
        beat_next = beat_reg;
        mode16_next = mode16_reg;
        pack_nz_next = pack_nz_reg;
        hold_next = hold_reg;
        flash_next = flash_reg;
        dur_next = dur_reg;
        ale_on_next = ale_on_reg;
        wr_n_next = wr_n_reg;
        ad_next = ad_reg;
        oe_next = oe_reg;
        ready_next = ready_reg;
        tmr_load = 1'b0;
        tmr_val = '0;
        case (state_reg)
            mppw_pkg::ST_IDLE: begin
                // Configuration other than ale_active_low is captured per request so a change to it cannot tear a group.
                if (req_valid && ready_reg) begin
                    addr_next = req_addr;
                    word_next = req_data;
                    beat_next = 2'h0;
                    mode16_next = mem_16bit;
                    pack_nz_next = (packing_select != '0);
                    hold_next = hold_cycle_en;
                    flash_next = flash_mode;
                    dur_next = strobe_duration_field;
                    ready_next = 1'b0;
                    state_next = mppw_pkg::ST_START;
                end
            end
            mppw_pkg::ST_START: begin
                if (tick) begin
                    ale_on_next = 1'b1;
                    ad_next = addr_reg;
                    oe_next = 1'b1;
                    tmr_load = 1'b1;
                    tmr_val = mppw_pkg::ALE_TICKS;
                    state_next = mppw_pkg::ST_ALE;
                end
            end
            mppw_pkg::ST_ALE: begin
                if (expired) begin
                    ale_on_next = 1'b0;
                    tmr_load = 1'b1;
                    tmr_val = mppw_pkg::ADDR_HOLD_TICKS;
                    state_next = mppw_pkg::ST_ADDR_HOLD;
                end
            end
            mppw_pkg::ST_ADDR_HOLD: begin
                if (expired) begin
                    ad_next = beat_bus;
                    tmr_load = 1'b1;
                    tmr_val = mppw_pkg::DATA_SETUP_TICKS;
                    state_next = mppw_pkg::ST_SETUP;
                end
            end
            mppw_pkg::ST_SETUP: begin
                if (expired) begin
                    wr_n_next = 1'b0;
                    tmr_load = 1'b1;
                    tmr_val = strobe_ticks;
                    state_next = mppw_pkg::ST_STROBE;
                end
            end
            mppw_pkg::ST_STROBE: begin
                if (expired) begin
                    wr_n_next = 1'b1;
                    tmr_load = 1'b1;
                    // Lines keep their value through the recovery; a zero recovery
                    // moves straight on, which is legal because the hold is zero too.
                    if (group_end) begin
                        tmr_val = hold_ticks;
                    end else begin
                        tmr_val = gap_ticks;
                    end
                    if (tmr_val != '0) begin
                        state_next = mppw_pkg::ST_RECOVER;
                    end else if (group_end) begin
                        tmr_load = 1'b0;
                        state_next = mppw_pkg::ST_START;
                    end else begin
                        ad_next = next_beat_bus;
                        beat_next = beat_inc;
                        tmr_val = mppw_pkg::DATA_SETUP_TICKS;
                        state_next = mppw_pkg::ST_SETUP;
                    end
                    if (tmr_val == '0 && group_end) begin
                        beat_next = beat_inc;
                        if (beat_reg == last_beat) begin
                            oe_next = 1'b0;
                            ready_next = 1'b1;
                            state_next = mppw_pkg::ST_IDLE;
                        end
                    end
                end
            end
            mppw_pkg::ST_RECOVER: begin
                if (expired) begin
                    if (!group_end) begin
                        ad_next = next_beat_bus;
                        beat_next = beat_inc;
                        tmr_load = 1'b1;
                        tmr_val = mppw_pkg::DATA_SETUP_TICKS;
                        state_next = mppw_pkg::ST_SETUP;
                    end else if (beat_reg == last_beat) begin
                        oe_next = 1'b0;
                        ready_next = 1'b1;
                        state_next = mppw_pkg::ST_IDLE;
                    end else begin
                        // Packed 16-bit halves each get their own latch cycle.
                        beat_next = beat_inc;
                        ale_on_next = 1'b1;
                        ad_next = addr_reg + AW'(beat_inc);
                        tmr_load = 1'b1;
                        tmr_val = mppw_pkg::ALE_TICKS;
                        state_next = mppw_pkg::ST_ALE;
                    end
                end
            end
            default: begin
                state_next = mppw_pkg::ST_IDLE;
            end
        endcase
        // The start state re-uses beat to address a later packed half.
        if (state_reg == mppw_pkg::ST_START && tick) begin
            ad_next = addr_reg + AW'(beat_reg);
        end
        ale_next = ale_on_next ^ ale_active_low;
    end

    // Register stage; the clock enable freezes everything.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= mppw_pkg::ST_IDLE;
            addr_reg <= mppw_pkg::AD_RESET;
            word_reg <= '0;
            beat_reg <= 2'h0;
            mode16_reg <= 1'b0;
            pack_nz_reg <= 1'b0;
            hold_reg <= 1'b0;
            flash_reg <= 1'b0;
            dur_reg <= '0;
            ale_on_reg <= 1'b0;
            ale_reg <= mppw_pkg::ALE_PIN_RESET;
            wr_n_reg <= mppw_pkg::WR_N_RESET;
            ad_reg <= mppw_pkg::AD_RESET;
            oe_reg <= 1'b0;
            ready_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            word_reg <= word_next;
            beat_reg <= beat_next;
            mode16_reg <= mode16_next;
            pack_nz_reg <= pack_nz_next;
            hold_reg <= hold_next;
            flash_reg <= flash_next;
            dur_reg <= dur_next;
            ale_on_reg <= ale_on_next;
            ale_reg <= ale_next;
            wr_n_reg <= wr_n_next;
            ad_reg <= ad_next;
            oe_reg <= oe_next;
            ready_reg <= (state_reg == mppw_pkg::ST_IDLE && state_next == mppw_pkg::ST_IDLE)
                ? 1'b1 : ready_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------
    assign req_ready = ready_reg;
    assign busy = oe_reg;
    assign ale = ale_reg;
    assign wr_n = wr_n_reg;
    assign muxed_addr_data_o = ad_reg;
    assign muxed_addr_data_oe = oe_reg;

endmodule : mppw_write_port

// ==== verif/mppw_mem_model.sv ====
`timescale 1ns/1ps
// Memory with an address latch; it logs each write it takes.
module mppw_mem_model (
    // Clock and control
    input wire logic clk,
    input wire logic clear,
    // Memory pins
    input wire logic ale,
    input wire logic ale_active_low,
    input wire logic wr_n,
    input wire logic [15:0] lines,
    // Write log
    output logic [4:0] log_cnt,
    output logic [15:0] log_addr [16],
    output logic [15:0] log_data [16]
);
    logic ale_on, ale_q, wr_q;
    logic [15:0] adr_q, latch_q, dat_q;
    assign ale_on = ale ^ ale_active_low;
    // Pins are looked at on clock edges, so a capture sees the value from before it moved.
    always @(posedge clk) begin
        ale_q <= ale_on;
        wr_q <= wr_n;
        if (ale_on) adr_q <= lines;
        if (ale_q && !ale_on) latch_q <= adr_q;
        if (!wr_n) dat_q <= lines;
        if (clear) begin
            log_cnt <= 5'h00;
        end else if (wr_n && !wr_q && log_cnt < 5'h10) begin
            log_addr[log_cnt[3:0]] <= latch_q;
            log_data[log_cnt[3:0]] <= dat_q;
            log_cnt <= log_cnt + 5'h01;
        end
    end
endmodule : mppw_mem_model

// ==== verif/mppw_write_port_chk.sv ====
`timescale 1ns/1ps
module mppw_write_port_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration
    input wire logic [mppw_pkg::DUR_W-1:0] strobe_duration_field,
    input wire logic hold_cycle_en,
    input wire logic flash_mode,
    input wire logic ale_active_low,
    // Memory pins
    input wire logic ale,
    input wire logic wr_n,
    input wire logic [mppw_pkg::AD_W-1:0] muxed_addr_data_o,
    input wire logic muxed_addr_data_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ----------------
    // Pulse counters
    // ----------------
    logic ale_on;
    logic gap_reg, gap_next;
    logic [7:0] lo_reg, lo_next, hi_reg, hi_next, s_clk, h_clk, g_clk;
    assign ale_on = ale ^ ale_active_low;
    // Widths in core cycles; the bench keeps the setup steady through each transfer.
    always_comb begin
        s_clk = 8'(strobe_duration_field);
        if (flash_mode) begin
            s_clk = (s_clk > 8'h07) ? s_clk - 8'h07 : 8'h01;
        end
        if (s_clk == 8'h00) begin
            s_clk = 8'h01;
        end
        s_clk = s_clk << 1;
        h_clk = hold_cycle_en ? 8'h02 : 8'h00;
        g_clk = 8'h02 + h_clk + (flash_mode ? 8'h0E : 8'h00);
        lo_next = wr_n ? 8'h00 : lo_reg + 8'h01;
        hi_next = !wr_n ? 8'h00 : (hi_reg == 8'hFF) ? hi_reg : hi_reg + 8'h01;
        gap_next = (ale_on || !muxed_addr_data_oe) ? 1'b0 : !wr_n ? 1'b1 : gap_reg;
    end
    // The high counter saturates, so a long idle spell cannot wrap it.
    always_ff @(posedge clk) begin
        if (rst) begin
            lo_reg <= 8'h00;
            hi_reg <= 8'h00;
            gap_reg <= 1'b0;
        end else begin
            lo_reg <= lo_next;
            hi_reg <= hi_next;
            gap_reg <= gap_next;
        end
    end
    // ----------------
    // Properties
    // ----------------
    sequence latch_pulse;
        ale_on [*4] ##1 !ale_on;
    endsequence
    sequence strobe_wait;
        wr_n [*4] ##1 !wr_n;
    endsequence
    a_latch_width: assert property ($rose(ale_on) && muxed_addr_data_oe |-> latch_pulse)
        else $error("latch strobe width wrong");
    a_addr_setup: assert property ($fell(ale_on) && muxed_addr_data_oe |->
        muxed_addr_data_o == $past(muxed_addr_data_o, 2)) else $error("address setup short");
    a_addr_hold: assert property ($fell(ale_on) && muxed_addr_data_oe |->
        $stable(muxed_addr_data_o) [*2]) else $error("address hold short");
    a_latch_to_strobe: assert property ($fell(ale_on) && muxed_addr_data_oe |-> strobe_wait)
        else $error("latch to strobe gap wrong");
    a_strobe_width: assert property ($rose(wr_n) |-> lo_reg == s_clk)
        else $error("write strobe width wrong");
    a_strobe_gap: assert property ($fell(wr_n) && gap_reg |-> hi_reg == g_clk)
        else $error("strobe recovery gap wrong");
    // The latch strobe never rises on the edge that raises the write strobe.
    a_group_end: assert property ($rose(ale_on) && muxed_addr_data_oe && gap_reg |->
        hi_reg == ((h_clk > 8'h02) ? h_clk : 8'h02)) else $error("strobe to next latch wrong");
    a_data_setup: assert property ($fell(wr_n) |->
        muxed_addr_data_o == $past(muxed_addr_data_o, 2)) else $error("data setup short");
    a_data_stable: assert property (!wr_n |-> $stable(muxed_addr_data_o) && muxed_addr_data_oe)
        else $error("data moved under strobe");
    a_data_hold: assert property ($rose(wr_n) && hold_cycle_en |->
        $stable(muxed_addr_data_o) [*2]) else $error("data hold short");
    a_idle_polarity: assert property (!muxed_addr_data_oe && !$past(muxed_addr_data_oe) &&
        $stable(ale_active_low) |-> ale == ale_active_low) else $error("idle latch level wrong");
endmodule : mppw_write_port_chk

bind mppw_write_port mppw_write_port_chk mppw_write_port_chk_inst (.clk(clk), .rst(rst),
    .strobe_duration_field(strobe_duration_field), .hold_cycle_en(hold_cycle_en),
    .flash_mode(flash_mode), .ale_active_low(ale_active_low), .ale(ale), .wr_n(wr_n),
    .muxed_addr_data_o(muxed_addr_data_o), .muxed_addr_data_oe(muxed_addr_data_oe));

// ==== verif/mppw_write_port_test.sv ====
`timescale 1ns/1ps
module mppw_write_port_test;
    typedef struct {
        logic m16, hold, flash, alow;
        logic [1:0] pack;
        logic [4:0] dur;
        logic [15:0] addr;
        logic [31:0] data;
        logic [4:0] n_exp;
    } mppw_row_s;
    logic clk = 1'b0, rst = 1'b1, log_clear = 1'b0;
    logic m16 = 1'b0, hold = 1'b0, flash = 1'b0, alow = 1'b0, req_valid = 1'b0;
    logic [1:0] pack = 2'h0;
    logic [4:0] dur = 5'h01;
    logic [15:0] req_addr = 16'h0000;
    logic [31:0] req_data = 32'h00000000;
    logic req_ready, busy, ale, wr_n, ad_oe;
    logic [15:0] ad;
    logic [4:0] log_cnt;
    logic [15:0] log_addr [16];
    logic [15:0] log_data [16];
    int fails = 0;
    int samples_checked = 0;
    // Each row: 16-bit, hold, flash, active-low latch, packing, duration, address, data, writes.
    mppw_row_s rows [9] = '{
        '{1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 5'h03, 16'h12FE, 32'hA1B2C3D4, 5'h04},
        '{1'b0, 1'b1, 1'b0, 1'b1, 2'h0, 5'h01, 16'h3400, 32'h01020304, 5'h04},
        '{1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 5'h09, 16'h00FF, 32'h5A6B7C8D, 5'h04},
        '{1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 5'h00, 16'h0001, 32'hFFFF0000, 5'h04},
        '{1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 5'h02, 16'h4000, 32'h89ABCDEF, 5'h02},
        '{1'b1, 1'b1, 1'b1, 1'b0, 2'h0, 5'h0A, 16'h7FFE, 32'h13572468, 5'h02},
        '{1'b1, 1'b0, 1'b0, 1'b0, 2'h1, 5'h04, 16'hFFFF, 32'h0F0F1234, 5'h02},
        '{1'b1, 1'b1, 1'b0, 1'b1, 2'h2, 5'h1F, 16'h2222, 32'h55AA33CC, 5'h02},
        '{1'b1, 1'b0, 1'b1, 1'b0, 2'h3, 5'h09, 16'h0100, 32'h600D0001, 5'h02}};

    mppw_write_port mppw_write_port_inst (.clk(clk), .rst(rst), .ce(1'b1),
        .strobe_duration_field(dur), .packing_select(pack), .mem_16bit(m16),
        .hold_cycle_en(hold), .flash_mode(flash), .ale_active_low(alow),
        .req_valid(req_valid), .req_addr(req_addr), .req_data(req_data),
        .req_ready(req_ready), .busy(busy), .ale(ale), .wr_n(wr_n),
        .muxed_addr_data_o(ad), .muxed_addr_data_oe(ad_oe));
    mppw_mem_model mppw_mem_model_inst (.clk(clk), .clear(log_clear), .ale(ale),
        .ale_active_low(alow), .wr_n(wr_n), .lines(ad), .log_cnt(log_cnt),
        .log_addr(log_addr), .log_data(log_data));

    // 40 MHz core clock.
    always #12.5 clk = ~clk;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick

    // Holds the request until the edge that takes it; a stuck port ends the wait.
    task automatic send(input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req_addr = a;
        req_data = d;
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        check("request taken", 32'(n < 100), 32'h1);
        tick(1);
    endtask : send

    // One extra cycle lets the memory log the final strobe before it is read.
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            tick(1);
            n++;
        end while (req_ready !== 1'b1 && n < 2000);
        check("ready after transfer", 32'(req_ready), 32'h1);
        check("busy after transfer", 32'(busy), 32'h0);
        tick(1);
    endtask : wait_idle

    // Beat i of a row: the latched address and what the lines carry at the strobe.
    task automatic expect_beat(input mppw_row_s r, input int i);
        logic [15:0] ea, ed;
        ea = (r.m16 && r.pack != 2'h0 && i == 1) ? r.addr + 16'h0001 : r.addr;
        ed = r.m16 ? r.data[16*i +: 16] : {r.addr[7:0] + 8'(i), r.data[8*i +: 8]};
        check("latched address", 32'(log_addr[i]), 32'(ea));
        check("written data", 32'(log_data[i]), 32'(ed));
    endtask : expect_beat

    task automatic run_row(input mppw_row_s r);
        log_clear = 1'b1;
        m16 = r.m16;
        hold = r.hold;
        flash = r.flash;
        alow = r.alow;
        pack = r.pack;
        dur = r.dur;
        tick(1);
        log_clear = 1'b0;
        send(r.addr, r.data);
        req_valid = 1'b0;
        wait_idle();
        check("write count", 32'(log_cnt), 32'(r.n_exp));
        for (int i = 0; i < 4; i++) begin
            if (i < r.n_exp) expect_beat(r, i);
        end
    endtask : run_row

    // Watchdog sized well above the longest expected run.
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        $display("watchdog expired");
        wrap_up();
    end

    initial begin
        tick(19);
        check("ale in reset", 32'(ale), 32'h0);
        check("wr_n in reset", 32'(wr_n), 32'h1);
        check("drive in reset", 32'(ad_oe), 32'h0);
        check("ready in reset", 32'(req_ready), 32'h0);
        tick(1);
        rst = 1'b0;
        tick(1);
        check("ready after reset", 32'(req_ready), 32'h1);
        alow = 1'b1;
        tick(2);
        check("idle latch active low", 32'(ale), 32'h1);
        alow = 1'b0;
        tick(2);
        check("idle latch active high", 32'(ale), 32'h0);
        $display("test reset finished");
        for (int i = 0; i < 9; i++) begin
            run_row(rows[i]);
            $display("test row %0d finished", i);
        end
        // Back-to-back: the second request waits at the port until ready returns.
        log_clear = 1'b1;
        tick(1);
        log_clear = 1'b0;
        send(16'h0A00, 32'h11112222);
        send(16'h0B00, 32'h33334444);
        req_valid = 1'b0;
        wait_idle();
        check("back to back count", 32'(log_cnt), 32'h4);
        check("second address", 32'(log_addr[2]), 32'h0B00);
        check("second data", 32'(log_data[3]), 32'h3333);
        $display("test back to back finished");
        // An abort under a long strobe must raise the write strobe and release the line drive.
        m16 = 1'b0;
        dur = 5'h1F;
        send(16'h5555, 32'h0);
        req_valid = 1'b0;
        tick(30);
        check("strobe under way", 32'(wr_n), 32'h0);
        check("busy under strobe", 32'(busy), 32'h1);
        rst = 1'b1;
        tick(3);
        check("wr_n after abort", 32'(wr_n), 32'h1);
        check("drive after abort", 32'(ad_oe), 32'h0);
        rst = 1'b0;
        tick(1);
        run_row(rows[3]);
        $display("test abort finished");
        wrap_up();
    end
endmodule : mppw_write_port_test
